// file: rtl/mss_memory_select.sv
`timescale 1ns/100ps
`default_nettype none

// Overview of operation
// - Up to six memories; memory A is always valid as fallback.
// - Mode decoded from switch type and dedicate-last settings into modes 1 to 4.
// - Pull-down polarity reads high as closed; pull-up reads low as closed.
// - Mode 1 starts in A; each press loads the next valid memory.
// - Press in last valid memory wraps to A; single memory stays A.
// - Mode 2 with input two open cycles like mode 1, skipping highest.
// - Mode 2 with input two closed jumps at once to highest valid memory.
// - Mode 2 with input two closed ignores presses; no change, no tone.
// - Mode 2 on input two opening restores prior memory; cycling resumes.
// - Mode 3 selects A, B, C, D in binary from the two inputs.
// - Static modes fall back to A when addressed memory is invalid, except mode 4 gives D even if D is invalid.
// - Static modes start in the memory the switches select at startup.
// - Static modes follow switches continuously; each switch loads the memory wanted at that moment, skipping settings passed during a fade.
// - Mode 4: input two closed gives D; else B if input one closed and B valid, else A.
// - Mode 4 ignores input one while input two is closed.
// - Dedicated static input two holds D for 1.5, 3.5, 5.5 s or none.
// - Each change fades out, plays tone if enabled, switches, fades in.
module mss_memory_select #(
   parameter int unsigned DEB_1_CYCLES = mss_pkg::DEB_1_MS * mss_pkg::CLK_KHZ,
   parameter int unsigned DEB_2_CYCLES = mss_pkg::DEB_2_MS * mss_pkg::CLK_KHZ,
   parameter int unsigned DEB_3_CYCLES = mss_pkg::DEB_3_MS * mss_pkg::CLK_KHZ
) (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // AXI4-Lite write address
   input wire logic [31:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   // AXI4-Lite write data
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   // AXI4-Lite write response
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   // AXI4-Lite read address
   input wire logic [31:0] araddr,
   input wire logic arvalid,
   output logic arready,
   // AXI4-Lite read data
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   // Switch pins
   input wire logic select_input_one,
   input wire logic select_input_two,
   // Memory and fader
   output logic [2:0] active_memory,
   output logic fade_out,
   output logic indicator_tone,
   output logic fade_in
);

   logic [mss_pkg::CTL_WIDTH-1:0] control;
   logic [mss_pkg::MEM_COUNT-1:0] valid_mask;
   logic [31:0] aw_addr_q;
   logic [31:0] w_data_q;
   logic [3:0] w_strb_q;
   logic aw_held;
   logic w_held;
   logic do_write;
   logic [31:0] next_rdata;
   logic next_rmapped;
   logic one_closed;
   logic one_pressed;
   logic two_closed;
   logic two_closed_d;
   logic two_hold;
   logic [31:0] hold_count;
   logic two_eff;
   logic [31:0] hold_limit;
   mss_pkg::mss_mode_type mode;
   logic [2:0] cyc_mem;
   logic [2:0] highest;
   logic [mss_pkg::MEM_COUNT-1:0] cycle_mask;
   logic [2:0] next_wanted;
   logic [2:0] start_count;
   logic started;
   mss_pkg::mss_seq_type seq;
   logic [15:0] seq_count;

   // ==========================================================
   // Helpers
   function automatic logic [2:0] next_in(input logic [2:0] cur, input logic [mss_pkg::MEM_COUNT-1:0] mask);
      logic [2:0] res;
      res = mss_pkg::MEM_A;
      for (int i = mss_pkg::MEM_COUNT - 1; i > 0; i--) begin
         if (mask[i] && (3'(i) > cur)) begin
            res = 3'(i);
         end
      end
      return res;
   endfunction : next_in

   function automatic logic [2:0] top_valid(input logic [mss_pkg::MEM_COUNT-1:0] mask);
      logic [2:0] res;
      res = mss_pkg::MEM_A;
      for (int i = 0; i < mss_pkg::MEM_COUNT; i++) begin
         if (mask[i]) begin
            res = 3'(i);
         end
      end
      return res;
   endfunction : top_valid

   // ==========================================================
   // Switch inputs
   mss_switch_input u_input_one (
      .aclk(aclk),
      .aresetn(aresetn),
      .pin_level(select_input_one),
      .pull_up(control[mss_pkg::CTL_POL_ONE]),
      .closed(one_closed),
      .pressed(one_pressed)
   );

   mss_switch_input u_input_two (
      .aclk(aclk),
      .aresetn(aresetn),
      .pin_level(select_input_two),
      .pull_up(control[mss_pkg::CTL_POL_TWO]),
      .closed(two_closed),
      .pressed()
   );

   // ==========================================================
   // AXI4-Lite write channel
   assign do_write = aw_held && w_held && !bvalid;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awready <= 1'b0;
         aw_held <= 1'b0;
         aw_addr_q <= 32'h0000_0000;
      end else if (awvalid && awready) begin
         awready <= 1'b0;
         aw_held <= 1'b1;
         aw_addr_q <= awaddr;
      end else if (do_write) begin
         aw_held <= 1'b0;
      end else if (!aw_held && !bvalid) begin
         awready <= 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wready <= 1'b0;
         w_held <= 1'b0;
         w_data_q <= 32'h0000_0000;
         w_strb_q <= 4'h0;
      end else if (wvalid && wready) begin
         wready <= 1'b0;
         w_held <= 1'b1;
         w_data_q <= wdata;
         w_strb_q <= wstrb;
      end else if (do_write) begin
         w_held <= 1'b0;
      end else if (!w_held && !bvalid) begin
         wready <= 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid <= 1'b0;
         bresp <= mss_pkg::RESP_OKAY;
      end else if (do_write) begin
         bvalid <= 1'b1;
         bresp <= (aw_addr_q == mss_pkg::OFS_CONTROL || aw_addr_q == mss_pkg::OFS_VALID
                   || aw_addr_q == mss_pkg::OFS_STATUS) ? mss_pkg::RESP_OKAY : mss_pkg::RESP_SLVERR;
      end else if (bready) begin
         bvalid <= 1'b0;
      end
   end

   // ==========================================================
   // Registers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         control <= mss_pkg::CTL_RESET;
         valid_mask <= mss_pkg::VALID_RESET;
      end else if (do_write && w_strb_q[0]) begin
         if (aw_addr_q == mss_pkg::OFS_CONTROL) begin
            control <= w_data_q[mss_pkg::CTL_WIDTH-1:0];
         end
         if (aw_addr_q == mss_pkg::OFS_VALID) begin
            valid_mask <= w_data_q[mss_pkg::MEM_COUNT-1:0] | mss_pkg::VALID_RESET;
         end
      end
   end

   // ==========================================================
   // AXI4-Lite read channel
   always_comb begin
      next_rdata = 32'h0000_0000;
      next_rmapped = 1'b1;
      if (araddr == mss_pkg::OFS_CONTROL) begin
         next_rdata[mss_pkg::CTL_WIDTH-1:0] = control;
      end else if (araddr == mss_pkg::OFS_VALID) begin
         next_rdata[mss_pkg::MEM_COUNT-1:0] = valid_mask;
      end else if (araddr == mss_pkg::OFS_STATUS) begin
         next_rdata[mss_pkg::STS_MEM_LO +: 3] = active_memory;
         next_rdata[mss_pkg::STS_MODE_LO +: 2] = mode;
         next_rdata[mss_pkg::STS_BUSY] = (seq != mss_pkg::SEQ_IDLE);
         next_rdata[mss_pkg::STS_ONE] = one_closed;
         next_rdata[mss_pkg::STS_TWO] = two_closed;
         next_rdata[mss_pkg::STS_HOLD] = two_hold;
      end else begin
         next_rmapped = 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready <= 1'b0;
         rvalid <= 1'b0;
         rdata <= 32'h0000_0000;
         rresp <= mss_pkg::RESP_OKAY;
      end else if (arvalid && arready) begin
         arready <= 1'b0;
         rvalid <= 1'b1;
         rdata <= next_rdata;
         rresp <= next_rmapped ? mss_pkg::RESP_OKAY : mss_pkg::RESP_SLVERR;
      end else if (rvalid && rready) begin
         rvalid <= 1'b0;
      end else if (!rvalid) begin
         arready <= 1'b1;
      end
   end

   // ==========================================================
   // Mode decode
   always_comb begin
      unique case ({control[mss_pkg::CTL_STATIC], control[mss_pkg::CTL_DEDICATE]})
         2'b00: mode = mss_pkg::MSS_MODE_1;
         2'b01: mode = mss_pkg::MSS_MODE_2;
         2'b10: mode = mss_pkg::MSS_MODE_3;
         2'b11: mode = mss_pkg::MSS_MODE_4;
      endcase
   end

   // ==========================================================
   // Input two release hold; keeps a passing head movement from leaving D
   always_comb begin
      unique case (control[mss_pkg::CTL_DEB_HI:mss_pkg::CTL_DEB_LO])
         2'b01: hold_limit = DEB_1_CYCLES;
         2'b10: hold_limit = DEB_2_CYCLES;
         2'b11: hold_limit = DEB_3_CYCLES;
         2'b00: hold_limit = 32'h0000_0001;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         two_closed_d <= 1'b0;
         two_hold <= 1'b0;
         hold_count <= 32'h0000_0000;
      end else begin
         two_closed_d <= two_closed;
         if (!control[mss_pkg::CTL_DEDICATE] || two_closed
             || control[mss_pkg::CTL_DEB_HI:mss_pkg::CTL_DEB_LO] == 2'b00) begin
            two_hold <= 1'b0;
         end else if (two_closed_d) begin
            two_hold <= 1'b1;
            hold_count <= hold_limit - 32'h0000_0001;
         end else if (two_hold) begin
            if (hold_count == 32'h0000_0000) begin
               two_hold <= 1'b0;
            end else begin
               hold_count <= hold_count - 32'h0000_0001;
            end
         end
      end
   end

   assign two_eff = two_closed || two_hold || (two_closed_d && control[mss_pkg::CTL_DEDICATE]
                    && control[mss_pkg::CTL_DEB_HI:mss_pkg::CTL_DEB_LO] != 2'b00);

   // ==========================================================
   // Momentary cycling
   assign highest = top_valid(valid_mask);
   assign cycle_mask = valid_mask & ~(mss_pkg::MEM_COUNT'(1) << highest) | mss_pkg::VALID_RESET;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cyc_mem <= mss_pkg::MEM_A;
      end else if (one_pressed && mode == mss_pkg::MSS_MODE_1) begin
         cyc_mem <= next_in(cyc_mem, valid_mask);
      end else if (one_pressed && mode == mss_pkg::MSS_MODE_2 && !two_eff) begin
         cyc_mem <= next_in(cyc_mem, cycle_mask);
      end
   end

   // ==========================================================
   // Wanted memory
   always_comb begin
      next_wanted = cyc_mem;
      unique case (mode)
         mss_pkg::MSS_MODE_1: next_wanted = cyc_mem;
         mss_pkg::MSS_MODE_2: next_wanted = two_eff ? highest : cyc_mem;
         mss_pkg::MSS_MODE_3: begin
            next_wanted = valid_mask[{two_closed, one_closed}] ? {1'b0, two_closed, one_closed}
                                                              : mss_pkg::MEM_A;
         end
         mss_pkg::MSS_MODE_4: begin
            if (two_eff) begin
               next_wanted = mss_pkg::MEM_D;
            end else if (one_closed && valid_mask[1]) begin
               next_wanted = mss_pkg::MEM_B;
            end else begin
               next_wanted = mss_pkg::MEM_A;
            end
         end
      endcase
   end

   // ==========================================================
   // Startup load, no fade before the switches have settled
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         start_count <= 3'h0;
         started <= 1'b0;
      end else if (!started) begin
         start_count <= start_count + 3'h1;
         started <= (start_count == mss_pkg::STARTUP_CYCLES - 3'h1);
      end
   end

   // ==========================================================
   // Fade sequencer
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         seq <= mss_pkg::SEQ_IDLE;
         seq_count <= 16'h0000;
         active_memory <= mss_pkg::MEM_A;
         fade_out <= 1'b0;
         indicator_tone <= 1'b0;
         fade_in <= 1'b0;
      end else begin
         unique case (seq)
            mss_pkg::SEQ_IDLE: begin
               if (!started) begin
                  active_memory <= next_wanted;
               end else if (next_wanted != active_memory) begin
                  seq <= mss_pkg::SEQ_FADE_OUT;
                  seq_count <= 16'(mss_pkg::FADE_CYCLES - 1);
                  fade_out <= 1'b1;
               end
            end
            mss_pkg::SEQ_FADE_OUT: begin
               if (seq_count != 16'h0000) begin
                  seq_count <= seq_count - 16'h0001;
               end else if (control[mss_pkg::CTL_TONE_EN]) begin
                  seq <= mss_pkg::SEQ_TONE;
                  seq_count <= 16'(mss_pkg::TONE_CYCLES - 1);
                  indicator_tone <= 1'b1;
               end else begin
                  seq <= mss_pkg::SEQ_FADE_IN;
                  seq_count <= 16'(mss_pkg::FADE_CYCLES - 1);
                  active_memory <= next_wanted;
                  fade_out <= 1'b0;
                  fade_in <= 1'b1;
               end
            end
            mss_pkg::SEQ_TONE: begin
               if (seq_count != 16'h0000) begin
                  seq_count <= seq_count - 16'h0001;
               end else begin
                  seq <= mss_pkg::SEQ_FADE_IN;
                  seq_count <= 16'(mss_pkg::FADE_CYCLES - 1);
                  active_memory <= next_wanted;
                  indicator_tone <= 1'b0;
                  fade_out <= 1'b0;
                  fade_in <= 1'b1;
               end
            end
            mss_pkg::SEQ_FADE_IN: begin
               if (seq_count != 16'h0000) begin
                  seq_count <= seq_count - 16'h0001;
               end else begin
                  seq <= mss_pkg::SEQ_IDLE;
                  fade_in <= 1'b0;
               end
            end
         endcase
      end
   end

   // ==========================================================
   // Checks
   localparam int CHANGE_BOUND = 720;

   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   sequence seq_change_start;
      seq == mss_pkg::SEQ_IDLE && started && next_wanted != active_memory;
   endsequence

   sequence seq_switch_done;
      fade_in && !fade_out && !indicator_tone;
   endsequence

   AST_MEM_A_VALID: assert property (valid_mask[0])
      else $error("memory A not valid");

   AST_MODE_DECODE: assert property (mode == mss_pkg::MSS_MODE_4 |-> control[mss_pkg::CTL_STATIC])
      else $error("mode 4 without static type");

   AST_WRAP: assert property (one_pressed && mode == mss_pkg::MSS_MODE_1 && cyc_mem == highest
                              |=> cyc_mem == mss_pkg::MEM_A)
      else $error("no wrap to memory A");

   AST_MODE2_JUMP: assert property (mode == mss_pkg::MSS_MODE_2 && two_eff |-> next_wanted == highest)
      else $error("mode 2 not at highest memory");

   AST_MODE2_IGNORE: assert property (mode == mss_pkg::MSS_MODE_2 && two_eff |=> $stable(cyc_mem))
      else $error("press taken while input two closed");

   AST_STATIC_FALLBACK: assert property (mode == mss_pkg::MSS_MODE_3
                                         && !valid_mask[{two_closed, one_closed}]
                                         |-> next_wanted == mss_pkg::MEM_A)
      else $error("invalid memory not replaced by A");

   AST_MODE4_D: assert property (mode == mss_pkg::MSS_MODE_4 && two_eff |-> next_wanted == mss_pkg::MEM_D)
      else $error("mode 4 not at memory D");

   AST_DEBOUNCE: assert property (control[mss_pkg::CTL_DEDICATE] && control[mss_pkg::CTL_DEB_LO]
                                  && two_closed_d && !two_closed |=> two_hold)
      else $error("release hold not started");

   AST_FADE_SEQ: assert property (seq_change_start |=> fade_out ##[1:CHANGE_BOUND] seq_switch_done)
      else $error("memory change without fade sequence");

   AST_SWITCH_MUTED: assert property ($changed(active_memory) && started && $past(started)
                                      |-> fade_in && $past(fade_out))
      else $error("memory switched outside fade");

   AST_PRESS_ONCE: assert property (one_pressed |=> !one_pressed)
      else $error("press held over two cycles");

endmodule : mss_memory_select

`default_nettype wire

// file: rtl/mss_pkg.sv
package mss_pkg;

   // ==========================================================
   // Memory set
   localparam int MEM_COUNT = 6;
   localparam logic [2:0] MEM_A = 3'h0;
   localparam logic [2:0] MEM_B = 3'h1;
   localparam logic [2:0] MEM_D = 3'h3;

   // ==========================================================
   // Register offsets (byte addresses)
   localparam logic [31:0] OFS_CONTROL = 32'h0000_0000;
   localparam logic [31:0] OFS_VALID = 32'h0000_0004;
   localparam logic [31:0] OFS_STATUS = 32'h0000_0008;

   // ==========================================================
   // Control fields
   localparam int CTL_STATIC = 0;
   localparam int CTL_DEDICATE = 1;
   localparam int CTL_POL_ONE = 2;
   localparam int CTL_POL_TWO = 3;
   localparam int CTL_DEB_LO = 4;
   localparam int CTL_DEB_HI = 5;
   localparam int CTL_TONE_EN = 6;
   localparam int CTL_WIDTH = 7;
   localparam logic [6:0] CTL_RESET = 7'h40;

   // ==========================================================
   // Valid mask and status fields
   localparam logic [5:0] VALID_RESET = 6'h01;
   localparam int STS_MEM_LO = 0;
   localparam int STS_MODE_LO = 3;
   localparam int STS_BUSY = 5;
   localparam int STS_ONE = 6;
   localparam int STS_TWO = 7;
   localparam int STS_HOLD = 8;

   // ==========================================================
   // AXI responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // ==========================================================
   // Timing
   localparam int CLK_KHZ = 100000;
   localparam int CLK_MHZ = 100;
   localparam int DEB_1_MS = 1500;
   localparam int DEB_2_MS = 3500;
   localparam int DEB_3_MS = 5500;
   localparam int FADE_US = 2;
   localparam int TONE_US = 5;
   localparam int FADE_CYCLES = FADE_US * CLK_MHZ;
   localparam int TONE_CYCLES = TONE_US * CLK_MHZ;
   localparam logic [2:0] STARTUP_CYCLES = 3'h4;

   // ==========================================================
   // Types
   typedef enum logic [1:0] {MSS_MODE_1, MSS_MODE_2, MSS_MODE_3, MSS_MODE_4} mss_mode_type;
   typedef enum logic [1:0] {SEQ_IDLE, SEQ_FADE_OUT, SEQ_TONE, SEQ_FADE_IN} mss_seq_type;

endpackage : mss_pkg

// file: rtl/mss_switch_input.sv
`timescale 1ns/100ps
`default_nettype none

module mss_switch_input (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Switch pin and setting
   input wire logic pin_level,
   input wire logic pull_up,
   // Decoded switch state
   output logic closed,
   output logic pressed
);

   logic sync_first;
   logic sync_second;
   logic next_closed;

   // ==========================================================
   // Synchroniser
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sync_first <= 1'b0;
         sync_second <= 1'b0;
      end else begin
         sync_first <= pin_level;
         sync_second <= sync_first;
      end
   end

   // ==========================================================
   // Polarity and press edge
   assign next_closed = pull_up ? !sync_second : sync_second;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         closed <= 1'b0;
         pressed <= 1'b0;
      end else begin
         closed <= next_closed;
         pressed <= next_closed && !closed;
      end
   end

endmodule : mss_switch_input

`default_nettype wire

// file: testbench/mss_memory_select_tb.sv
`timescale 1ns/100ps
`default_nettype none

module mss_memory_select_tb;
   logic aclk = 1'h0;
   logic aresetn = 1'h0;
   logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, rdata, rd, seed = 32'h44, r;
   logic [3:0] wstrb = 4'hf;
   logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
   logic awready, wready, bvalid, arready, rvalid, fade_out, indicator_tone, fade_in, pin_one, pin_two;
   logic [1:0] bresp, rresp, rs, bs;
   logic [2:0] active_memory, prev_mem;
   logic closed_one = 1'h0, closed_two = 1'h0, up_one = 1'h0, up_two = 1'h0, tone_seen = 1'h0;
   int num_errors = 0, checked = 0, cycles = 0;

   always #5 aclk = ~aclk;

   // Short hold counts keep the release delay visible in simulation
   mss_memory_select #(.DEB_1_CYCLES(20), .DEB_2_CYCLES(40), .DEB_3_CYCLES(60)) u_dut (
      .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
      .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
      .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
      .rresp(rresp), .rvalid(rvalid), .rready(rready), .select_input_one(pin_one),
      .select_input_two(pin_two), .active_memory(active_memory), .fade_out(fade_out),
      .indicator_tone(indicator_tone), .fade_in(fade_in));

   mss_switch_model u_sw (.closed_one(closed_one), .closed_two(closed_two), .up_one(up_one),
      .up_two(up_two), .pin_one(pin_one), .pin_two(pin_two));

   // ====================
   // Reporting and checks
   task automatic err(input string m);
      $display("[FAIL] %0t %s", $time, m);
      num_errors++;
   endtask : err

   task automatic chk_val(input logic [31:0] got, input logic [31:0] exp, input string m);
      checked++;
      if (got !== exp) err(m);
   endtask : chk_val

   task automatic chk_mem(input logic [2:0] exp);
      checked++;
      if (active_memory !== exp) err("active memory");
   endtask : chk_mem

   task automatic finish_test();
      $display("Checks %0d, errors %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : finish_test

   // Memory may only change together with the fade-in
   always @(posedge aclk) begin
      cycles <= cycles + 1;
      prev_mem <= active_memory;
      if (indicator_tone === 1'h1) tone_seen <= 1'h1;
      if (cycles > 30 && active_memory !== prev_mem && fade_in !== 1'h1) err("change outside fade");
      if (cycles == 90000) begin
         num_errors++;
         finish_test();
      end
   end

   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : xs

   function automatic logic [2:0] exp_static(input logic ded, s1, s2, input logic [5:0] v);
      logic [2:0] m;
      if (ded && s2) return mss_pkg::MEM_D;
      m = ded ? {2'h0, s1} : {1'h0, s2, s1};
      return v[m] ? m : mss_pkg::MEM_A;
   endfunction : exp_static

   // ====================
   // Bus and switch actions
   task automatic axi_write(input logic [31:0] a, input logic [31:0] d);
      logic aw;
      logic w;
      aw = 1'h1;
      w = 1'h1;
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      while (aw || w) begin
         @(posedge aclk);
         if (aw && awready === 1'h1) begin
            aw = 1'h0;
            awvalid <= 1'h0;
         end
         if (w && wready === 1'h1) begin
            w = 1'h0;
            wvalid <= 1'h0;
         end
      end
      bready <= 1'h1;
      @(posedge aclk);
      while (bvalid !== 1'h1) @(posedge aclk);
      bs = bresp;
      bready <= 1'h0;
   endtask : axi_write

   task automatic axi_read(input logic [31:0] a);
      araddr <= a;
      arvalid <= 1'h1;
      @(posedge aclk);
      while (arready !== 1'h1) @(posedge aclk);
      arvalid <= 1'h0;
      rready <= 1'h1;
      @(posedge aclk);
      while (rvalid !== 1'h1) @(posedge aclk);
      rd = rdata;
      rs = rresp;
      rready <= 1'h0;
   endtask : axi_read

   task automatic settle(input int pre);
      repeat (pre) @(posedge aclk);
      while (fade_out === 1'h1 || fade_in === 1'h1) @(posedge aclk);
   endtask : settle

   task automatic press();
      closed_one <= 1'h1;
      repeat (10) @(posedge aclk);
      closed_one <= 1'h0;
      settle(8);
   endtask : press

   // ====================
   // Main sequence
   initial begin
      repeat (10) @(posedge aclk);
      aresetn <= 1'h1;
      @(posedge aclk);
      axi_read(mss_pkg::OFS_CONTROL);
      chk_val(rd, 32'h40, "control reset");
      chk_val({30'h0, rs}, {30'h0, mss_pkg::RESP_OKAY}, "read response");
      axi_write(mss_pkg::OFS_VALID, 32'h3e);
      chk_val({30'h0, bs}, {30'h0, mss_pkg::RESP_OKAY}, "write response");
      axi_read(mss_pkg::OFS_VALID);
      chk_val(rd, 32'h3f, "memory A valid");
      axi_read(32'h10);
      chk_val({30'h0, rs}, {30'h0, mss_pkg::RESP_SLVERR}, "unmapped read");
      axi_write(32'h10, 32'h0);
      chk_val({30'h0, bs}, {30'h0, mss_pkg::RESP_SLVERR}, "unmapped write");
      axi_write(mss_pkg::OFS_VALID, 32'h1);
      for (int i = 0; i < 4; i++) begin
         axi_write(mss_pkg::OFS_CONTROL, {30'h0, i[1], i[0]});
         axi_read(mss_pkg::OFS_STATUS);
         chk_val({30'h0, rd[4:3]}, {30'h0, i[0], i[1]}, "mode decode");
      end
      axi_write(mss_pkg::OFS_CONTROL, 32'h40);
      axi_write(mss_pkg::OFS_VALID, 32'hf);
      tone_seen <= 1'h0;
      press();
      chk_mem(mss_pkg::MEM_B);
      chk_val({31'h0, tone_seen}, 32'h1, "no tone");
      closed_one <= 1'h1;
      settle(8);
      repeat (20) @(posedge aclk);
      chk_mem(3'h2);
      chk_val({31'h0, fade_out}, 32'h0, "held switch advanced");
      closed_one <= 1'h0;
      repeat (5) @(posedge aclk);
      press();
      press();
      chk_mem(mss_pkg::MEM_A);
      axi_write(mss_pkg::OFS_VALID, 32'h1);
      press();
      chk_mem(mss_pkg::MEM_A);
      axi_write(mss_pkg::OFS_VALID, 32'hf);
      axi_write(mss_pkg::OFS_CONTROL, 32'h42);
      press();
      chk_mem(mss_pkg::MEM_B);
      closed_two <= 1'h1;
      settle(8);
      chk_mem(mss_pkg::MEM_D);
      tone_seen <= 1'h0;
      press();
      chk_mem(mss_pkg::MEM_D);
      chk_val({31'h0, tone_seen}, 32'h0, "tone while ignored");
      closed_two <= 1'h0;
      settle(8);
      chk_mem(mss_pkg::MEM_B);
      press();
      press();
      chk_mem(mss_pkg::MEM_A);
      axi_write(mss_pkg::OFS_CONTROL, 32'h53);
      closed_two <= 1'h1;
      settle(8);
      tone_seen <= 1'h0;
      press();
      chk_mem(mss_pkg::MEM_D);
      chk_val({31'h0, tone_seen}, 32'h0, "tone in mode 4");
      closed_two <= 1'h0;
      repeat (15) @(posedge aclk);
      chk_val({31'h0, fade_out}, 32'h0, "left D early");
      settle(30);
      chk_mem(mss_pkg::MEM_A);
      repeat (16) begin
         r = xs();
         axi_write(mss_pkg::OFS_VALID, {26'h0, r[5:1], 1'h1});
         axi_write(mss_pkg::OFS_CONTROL, {28'h0, r[10:9], r[8], 1'h1});
         up_one <= r[9];
         up_two <= r[10];
         closed_one <= r[6];
         closed_two <= r[7];
         settle(8);
         chk_mem(exp_static(r[8], r[6], r[7], {r[5:1], 1'h1}));
      end
      finish_test();
   end
endmodule : mss_memory_select_tb

`default_nettype wire

// file: testbench/mss_switch_model.sv
`timescale 1ns/100ps
`default_nettype none

// ====================
// Switch contacts with wiring polarity
module mss_switch_model (
   // Contact state and wiring
   input wire logic closed_one,
   input wire logic closed_two,
   input wire logic up_one,
   input wire logic up_two,
   // Pin levels
   output logic pin_one,
   output logic pin_two
);
   // Pull-up wiring reads low when closed; levels never float
   assign pin_one = closed_one ^ up_one;
   assign pin_two = closed_two ^ up_two;
endmodule : mss_switch_model

`default_nettype wire
